/* File: core/spd_regs.vh */
// Register offsets, field positions, reset values and timing counts of the positioner
`ifndef SPD_REGS_VH
`define SPD_REGS_VH
// Register byte offsets
`define SPD_CTRL_OFF 12'h000
`define SPD_CMD_OFF 12'h004
`define SPD_FBPOS_OFF 12'h008
`define SPD_THR_OFF 12'h00c
`define SPD_ACTPOS_OFF 12'h010
`define SPD_TARGET_OFF 12'h014
`define SPD_STATUS_OFF 12'h018
// Control fields
`define SPD_CTRL_MODE_LSB 0
`define SPD_CTRL_SHAFT_BIT 2
`define SPD_CTRL_RUN_BIT 3
`define SPD_CTRL_RUNDIR_BIT 4
// Command fields
`define SPD_CMD_KIND_LSB 30
`define SPD_KIND_FULL 2'h0
`define SPD_KIND_COMPACT 2'h1
`define SPD_KIND_FALLBACK 2'h2
// Stepping modes
`define SPD_MODE_HALF 2'h0
`define SPD_MODE_QUARTER 2'h1
`define SPD_MODE_EIGHTH 2'h2
`define SPD_MODE_SIXTEENTH 2'h3
// Status fields
`define SPD_ST_MOVING_BIT 0
`define SPD_ST_STALL_BIT 1
`define SPD_ST_FBDIS_BIT 2
`define SPD_ST_DIR_BIT 3
// Reserved fallback code that disables the fallback feature
`define SPD_FB_DISABLE 11'h400
// Reset values
`define SPD_CTRL_RST 5'h03
`define SPD_THR_LO_RST 8'h10
`define SPD_THR_HI_RST 8'hf0
// Step timing
`define SPD_STEP_TIME_NS 10000
`define SPD_CLK_PERIOD_NS 10
`define SPD_STEP_CYCLES (`SPD_STEP_TIME_NS / `SPD_CLK_PERIOD_NS)
`define SPD_AVG_SHIFT 3
`endif

/* File: core/spd_pos_align.v */
// Alignment of received position words into 1/16-step target values
`include "spd_regs.vh"
module spd_pos_align (
   // Command word
   input wire [1:0] kind,
   input wire [15:0] value,
   // Held fallback position
   input wire [10:0] fallback,
   // Aligned target, signed, 1/16-step units
   output reg [15:0] target
);
   // Select alignment by command kind
   always @* begin
      case (kind)
         `SPD_KIND_FULL: target = value;
         // Sign-extend 11 bits on top, three zero bits below
         `SPD_KIND_COMPACT: target = {{2{value[10]}}, value[10:0], 3'h0};
         // Fallback sits in the top 11 bits, five zero bits below
         `SPD_KIND_FALLBACK: target = {fallback, 5'h00};
         default: target = value;
      endcase
   end
endmodule // spd_pos_align

/* File: core/spd_stall_det.v */
// Back-emf moving average with two independent thresholds
`include "spd_regs.vh"
module spd_stall_det #(
   parameter W = 8
) (
   // Clock and reset
   input wire clk,
   input wire nrst,
   // Back-emf samples
   input wire [W-1:0] bemf,
   input wire bemf_valid,
   input wire active,
   // Thresholds
   input wire [W-1:0] thr_lo,
   input wire [W-1:0] thr_hi,
   // One-cycle stall indication
   output reg stall
);
   reg [W+`SPD_AVG_SHIFT-1:0] acc_r;
   wire [W-1:0] avg;
   assign avg = acc_r[W+`SPD_AVG_SHIFT-1:`SPD_AVG_SHIFT];
   // Running sum: drop one eighth, add the new sample
   always @(posedge clk) begin
      if (!nrst) begin
         acc_r <= {(W+`SPD_AVG_SHIFT){1'b0}};
         stall <= 1'b0;
      end else begin
         if (bemf_valid)
            acc_r <= acc_r - {{`SPD_AVG_SHIFT{1'b0}}, avg} + {{`SPD_AVG_SHIFT{1'b0}}, bemf};
         // Compare against both levels while the motor runs
         stall <= active && bemf_valid && ((avg < thr_lo) || (avg > thr_hi));
      end
   end
endmodule // spd_stall_det

/* File: core/spd_positioner.v */
// Stepper position word decoder and position controller with APB registers
//
// Functional notes
// - Compact and fallback values are aligned by the device itself.
// - Every position value is read as signed two's complement.
// - Full positions span 13 to 16 bits by mode; compact spans 11 bits.
// - Fallback is 11 bits in the top of the word, five zeros below.
// - One fallback LSB equals 32 sixteenth-steps, 4 half-steps.
// - Fallback code 0x400 disables the fallback feature.
// - At start-up fallback is copied from OTP with its two lowest bits cleared.
// - Direction-invert bit comes from OTP or the motor parameter command.
// - Invert bit 0 keeps X coil pin roles; bit 1 swaps them.
// - Continuous-run mode ignores the direction-invert bit.
// - Stall check averages back-emf and compares with two thresholds.
// - A back-emf excursion past a threshold stops the running motor.
// - Full, compact and enabled fallback commands replace the set point at once; outside continuous run the motor starts or stops to reach it.
// - Full targets move the shortest way round the circular position space.
`include "spd_regs.vh"
module spd_positioner #(
   parameter STEP_CYCLES = `SPD_STEP_CYCLES,
   parameter BEMF_W = 8
) (
   // Clock and reset
   input wire clk,
   input wire nrst,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // One-time-programmable settings
   input wire [10:0] otp_fallback,
   input wire otp_shaft,
   // Back-emf sense
   input wire [BEMF_W-1:0] bemf_sample,
   input wire bemf_valid,
   // Motor drive
   output reg coil_x_plus_pin,
   output reg coil_x_minus_pin,
   output reg coil_y_sign,
   output reg step_pulse,
   output reg moving
);
   // Control and configuration registers
   reg [1:0] mode_r;
   reg shaft_r;
   reg run_r;
   reg run_dir_r;
   reg [10:0] fallback_r;
   reg [BEMF_W-1:0] thr_lo_r;
   reg [BEMF_W-1:0] thr_hi_r;
   reg boot_r;
   // Position state
   reg [15:0] actpos_r;
   reg [15:0] target_r;
   reg [1:0] phase_r;
   reg dir_r;
   reg stalled_r;
   reg [15:0] timer_r;
   // Motion state machine
   localparam ST_IDLE = 3'b001;
   localparam ST_MOVE = 3'b010;
   localparam ST_RUN = 3'b100;
   reg [2:0] state_r;
   reg [2:0] state_nxt;
   // Control reset word, so the mode field can be sliced at its own width
   localparam [4:0] CTRL_RST_V = `SPD_CTRL_RST;
   // Bus decode
   wire bus_acc;
   wire bus_wr;
   wire bus_rd;
   wire cmd_wr;
   wire [15:0] aligned;
   wire stall_hit;
   wire fb_disabled;
   wire [15:0] diff;
   wire [15:0] step_sz;
   wire near;
   wire tick;
   wire step_now;
   wire coil_swap;
   reg [31:0] rdata_nxt;
   reg map_ok;

   // Step size in 1/16 units for a stepping mode
   function [15:0] step_of;
      input [1:0] m;
      begin
         case (m)
            `SPD_MODE_HALF: step_of = 16'h0008;
            `SPD_MODE_QUARTER: step_of = 16'h0004;
            `SPD_MODE_EIGHTH: step_of = 16'h0002;
            default: step_of = 16'h0001;
         endcase
      end
   endfunction

   // Magnitude of a signed 16-bit distance
   function [15:0] mag16;
      input [15:0] v;
      begin
         mag16 = v[15] ? (~v + 16'h0001) : v;
      end
   endfunction

   // Access phase strobes; pready is high in the first cycle of the access phase
   assign bus_acc = psel && penable && pready;
   assign bus_wr = bus_acc && pwrite;
   assign bus_rd = bus_acc && !pwrite;
   assign cmd_wr = bus_wr && (paddr == `SPD_CMD_OFF);

   // Reserved code marks the fallback feature as off
   assign fb_disabled = (fallback_r == `SPD_FB_DISABLE);

   // Word alignment of incoming commands
   spd_pos_align u_align (
      .kind(pwdata[`SPD_CMD_KIND_LSB+1:`SPD_CMD_KIND_LSB]),
      .value(pwdata[15:0]),
      .fallback(fallback_r),
      .target(aligned)
   );

   // Back-emf supervision while the motor turns
   spd_stall_det #(
      .W(BEMF_W)
   ) u_stall (
      .clk(clk),
      .nrst(nrst),
      .bemf(bemf_sample),
      .bemf_valid(bemf_valid),
      .active(state_r != ST_IDLE),
      .thr_lo(thr_lo_r),
      .thr_hi(thr_hi_r),
      .stall(stall_hit)
   );

   // Distance on the circle; the 16-bit wrap picks the shorter way
   assign diff = target_r - actpos_r;
   assign step_sz = step_of(mode_r);
   assign near = (mag16(diff) < step_sz);
   assign tick = (timer_r == 16'h0000);
   assign step_now = tick && (state_r != ST_IDLE) && !stall_hit;
   // The invert bit has no effect in continuous run
   assign coil_swap = shaft_r && (state_r != ST_RUN);

   // Register configuration, start-up copy and command intake
   always @(posedge clk) begin
      if (!nrst) begin
         mode_r <= CTRL_RST_V[`SPD_CTRL_MODE_LSB+1:`SPD_CTRL_MODE_LSB];
         shaft_r <= 1'b0;
         run_r <= 1'b0;
         run_dir_r <= 1'b0;
         fallback_r <= `SPD_FB_DISABLE;
         thr_lo_r <= `SPD_THR_LO_RST;
         thr_hi_r <= `SPD_THR_HI_RST;
         boot_r <= 1'b1;
         target_r <= 16'h0000;
      end else begin
         boot_r <= 1'b0;
         if (boot_r) begin
            // Start-up copy keeps nine bits of resolution
            fallback_r <= {otp_fallback[10:2], 2'b00};
            shaft_r <= otp_shaft;
         end else begin
            if (bus_wr && (paddr == `SPD_CTRL_OFF)) begin
               mode_r <= pwdata[`SPD_CTRL_MODE_LSB+1:`SPD_CTRL_MODE_LSB];
               shaft_r <= pwdata[`SPD_CTRL_SHAFT_BIT];
               run_r <= pwdata[`SPD_CTRL_RUN_BIT];
               run_dir_r <= pwdata[`SPD_CTRL_RUNDIR_BIT];
            end
            if (bus_wr && (paddr == `SPD_FBPOS_OFF))
               fallback_r <= pwdata[10:0];
            if (bus_wr && (paddr == `SPD_THR_OFF)) begin
               thr_lo_r <= pwdata[BEMF_W-1:0];
               thr_hi_r <= pwdata[2*BEMF_W-1:BEMF_W];
            end
         end
         // Full, compact and enabled fallback commands override the set point at once
         if (cmd_wr) begin
            case (pwdata[`SPD_CMD_KIND_LSB+1:`SPD_CMD_KIND_LSB])
               `SPD_KIND_FULL: target_r <= aligned;
               `SPD_KIND_COMPACT: target_r <= aligned;
               `SPD_KIND_FALLBACK: begin
                  if (!fb_disabled)
                     target_r <= aligned;
               end
               default: target_r <= target_r;
            endcase
         end else if (stall_hit) begin
            // A stall parks the set point where the rotor stands
            target_r <= actpos_r;
         end
      end
   end

   // Next motion state
   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (run_r && !stalled_r)
               state_nxt = ST_RUN;
            else if (!near && !stalled_r)
               state_nxt = ST_MOVE;
         end
         ST_MOVE: begin
            if (stall_hit)
               state_nxt = ST_IDLE;
            else if (run_r)
               state_nxt = ST_RUN;
            else if (near)
               state_nxt = ST_IDLE;
         end
         ST_RUN: begin
            if (stall_hit || !run_r)
               state_nxt = ST_IDLE;
         end
         default: state_nxt = ST_IDLE;
      endcase
   end

   // Motion sequencing, step timing and stall flag
   always @(posedge clk) begin
      if (!nrst) begin
         state_r <= ST_IDLE;
         actpos_r <= 16'h0000;
         phase_r <= 2'b00;
         dir_r <= 1'b0;
         stalled_r <= 1'b0;
         timer_r <= 16'h0000;
         step_pulse <= 1'b0;
         moving <= 1'b0;
      end else begin
         state_r <= state_nxt;
         moving <= (state_nxt != ST_IDLE);
         step_pulse <= step_now;
         // Step period counter, reloaded on each step
         if (state_r == ST_IDLE || tick)
            timer_r <= STEP_CYCLES[15:0] - 16'h0001;
         else
            timer_r <= timer_r - 16'h0001;
         // Direction follows the run direction bit in continuous run, else the sign of the shortest distance
         if (state_r == ST_RUN)
            dir_r <= run_dir_r;
         else
            dir_r <= diff[15];
         if (step_now) begin
            if ((state_r == ST_RUN) ? run_dir_r : diff[15]) begin
               actpos_r <= actpos_r - step_sz;
               phase_r <= phase_r - 2'b01;
            end else begin
               actpos_r <= actpos_r + step_sz;
               phase_r <= phase_r + 2'b01;
            end
         end
         // Stall is sticky; a set wins over a clear in the same cycle
         if (stall_hit)
            stalled_r <= 1'b1;
         else if (bus_wr && (paddr == `SPD_STATUS_OFF) && pwdata[`SPD_ST_STALL_BIT])
            stalled_r <= 1'b0;
         else if (cmd_wr)
            stalled_r <= 1'b0;
      end
   end

   // X coil polarity with optional swap of the pin roles
   always @(posedge clk) begin
      if (!nrst) begin
         coil_x_plus_pin <= 1'b0;
         coil_x_minus_pin <= 1'b0;
         coil_y_sign <= 1'b0;
      end else begin
         coil_x_plus_pin <= phase_r[1] ^ coil_swap;
         coil_x_minus_pin <= ~(phase_r[1] ^ coil_swap);
         coil_y_sign <= phase_r[1] ^ phase_r[0];
      end
   end

   // Read multiplexer and map check
   always @* begin
      rdata_nxt = 32'h00000000;
      map_ok = 1'b1;
      case (paddr)
         `SPD_CTRL_OFF: rdata_nxt = {27'h0000000, run_dir_r, run_r, shaft_r, mode_r};
         `SPD_CMD_OFF: rdata_nxt = 32'h00000000;
         `SPD_FBPOS_OFF: rdata_nxt = {21'h000000, fallback_r};
         `SPD_THR_OFF: rdata_nxt = {{(32-2*BEMF_W){1'b0}}, thr_hi_r, thr_lo_r};
         `SPD_ACTPOS_OFF: rdata_nxt = {16'h0000, actpos_r};
         `SPD_TARGET_OFF: rdata_nxt = {16'h0000, target_r};
         `SPD_STATUS_OFF: rdata_nxt = {28'h0000000, dir_r, fb_disabled, stalled_r, moving};
         default: map_ok = 1'b0;
      endcase
   end

   // APB answer: no wait states, error on unmapped offsets
   always @(posedge clk) begin
      if (!nrst) begin
         pready <= 1'b0;
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         if (psel && !penable) begin
            prdata <= pwrite ? 32'h00000000 : rdata_nxt;
            pslverr <= !map_ok || (paddr[1:0] != 2'b00);
         end else if (bus_acc) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
         end
      end
   end
endmodule // spd_positioner

/* File: tb/spd_props.sv */
// Port-level checks of the positioner
module spd_props #(
   parameter STEP_CYCLES = 4,
   parameter BEMF_W = 8
) (
   // Clock and reset
   input logic clk,
   input logic nrst,
   // APB
   input logic psel,
   input logic penable,
   input logic pwrite,
   input logic [11:0] paddr,
   input logic [31:0] pwdata,
   input logic [31:0] prdata,
   input logic pready,
   input logic pslverr,
   // Settings and sense
   input logic [10:0] otp_fallback,
   input logic otp_shaft,
   input logic [BEMF_W-1:0] bemf_sample,
   input logic bemf_valid,
   // Drive
   input logic coil_x_plus_pin,
   input logic coil_x_minus_pin,
   input logic coil_y_sign,
   input logic step_pulse,
   input logic moving
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // Setup cycle of a transfer, and the quiet run between steps
   sequence apb_setup;
      psel && !penable;
   endsequence
   sequence step_gap;
      !step_pulse [*3];
   endsequence
   pready_setup_a: assert property (apb_setup |=> pready)
      else $error("no pready after setup");
   pready_only_a: assert property (pready |-> $past(psel) && !$past(penable))
      else $error("stray pready");
   rdata_hold_a: assert property (!psel |=> $stable(prdata) && $stable(pslverr))
      else $error("read data moved while idle");
   reset_out_a: assert property (!$past(nrst) |-> !(moving || step_pulse || pready))
      else $error("output active in reset");
   coil_compl_a: assert property ($past(nrst) |-> coil_x_plus_pin != coil_x_minus_pin)
      else $error("coil pins not complementary");
   step_space_a: assert property (step_pulse |=> step_gap)
      else $error("steps too close");
   step_move_a: assert property (step_pulse |-> moving || $past(moving))
      else $error("step while idle");
   move_step_a: assert property ($rose(moving) |-> ##[1:8] (step_pulse || !moving))
      else $error("motion without step");
endmodule // spd_props

/* File: tb/spd_apb_mst.sv */
// APB master model that issues positioner commands
module spd_apb_mst (
   // Clock
   input logic clk,
   // Request
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata,
   // Answer
   input logic [31:0] prdata,
   input logic pready,
   input logic pslverr
);
   timeunit 1ns;
   timeprecision 1ns;
   // Idle bus at time zero
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
   end
   // One transfer held until pready; released address and data lines show the inverse
   task xfer(input logic w, input logic [11:0] ad, input logic [31:0] d,
             output logic [31:0] rdat, output logic err);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rdat = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~ad;
      pwdata <= ~d;
   endtask
endmodule // spd_apb_mst

/* File: tb/tb_stepper_position_word_decoder.sv */
// Self-checking bench of the positioner
`include "spd_regs.vh"
module tb_stepper_position_word_decoder;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {logic [10:0] fb; logic [1:0] k; logic [15:0] v; logic [15:0] x;} spd_row_t;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [10:0] otp_fb = 11'h3ff;
   logic otp_sh = 1'b0;
   logic [7:0] bemf = 8'h00;
   logic bvld = 1'b0;
   wire psel, penable, pwrite, pready, pslverr, cxp, cxn, cys, stp, mov;
   wire [11:0] paddr;
   wire [31:0] pwdata, prdata;
   int failures = 0;
   int tests_run = 0;
   logic [31:0] r, a;
   logic e, p;
   // Fallback, kind, word sent, expected target
   spd_row_t rows [8] = '{
      '{11'h3ff, 2'h0, 16'h8000, 16'h8000},
      '{11'h3ff, 2'h0, 16'h7ff8, 16'h7ff8},
      '{11'h3ff, 2'h1, 16'h0400, 16'he000},
      '{11'h3ff, 2'h1, 16'hfbff, 16'h1ff8},
      '{11'h3ff, 2'h2, 16'h0000, 16'h7fe0},
      '{11'h001, 2'h2, 16'h0000, 16'h0020},
      '{11'h7ff, 2'h2, 16'h0000, 16'hffe0},
      '{11'h400, 2'h2, 16'h0000, 16'hffe0}};
   always #5 clk = ~clk;
   spd_apb_mst i_mst (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   spd_positioner #(.STEP_CYCLES(4)) i_dut (.clk(clk), .nrst(nrst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .otp_fallback(otp_fb), .otp_shaft(otp_sh),
      .bemf_sample(bemf), .bemf_valid(bvld), .coil_x_plus_pin(cxp), .coil_x_minus_pin(cxn),
      .coil_y_sign(cys), .step_pulse(stp), .moving(mov));
   task close_out;
      if (failures == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] x, input logic [31:0] g);
      tests_run++;
      if (g !== x) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", n, x, g);
      end
   endtask
   task wr(input logic [11:0] ad, input logic [31:0] d);
      i_mst.xfer(1'b1, ad, d, r, e);
   endtask
   task rd(input logic [11:0] ad);
      i_mst.xfer(1'b0, ad, 32'h0, r, e);
   endtask
   task rst(input logic [10:0] o);
      otp_fb <= o;
      nrst <= 1'b0;
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
   endtask
   // Park the motor on its actual position
   task stop;
      rd(`SPD_ACTPOS_OFF);
      a = r;
      wr(`SPD_CMD_OFF, {16'h0, r[15:0]});
      repeat (3) @(posedge clk);
      // The rotor may still be a few steps past the parked point
      repeat (64) if (mov) @(posedge clk);
      chk("moving", 32'h0, mov);
      // Sixteenth steps of one unit: coil phase follows the two low position bits
      chk("coil_y", a[1] ^ a[0], cys);
      chk("coil_x", a[1], cxp);
   endtask
   task pulse;
      bemf <= 8'hff;
      bvld <= 1'b1;
      @(posedge clk);
      bvld <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   // Watchdog
   initial begin
      #100000;
      failures++;
      close_out;
   end
   // Main sequence
   initial begin
      rst(11'h3ff);
      rd(`SPD_CTRL_OFF);
      chk("ctrl", 32'h3, r);
      rd(`SPD_FBPOS_OFF);
      chk("fbpos", 32'h3fc, r);
      rd(`SPD_THR_OFF);
      chk("thr", 32'hf010, r);
      foreach (rows[i]) begin
         wr(`SPD_FBPOS_OFF, {21'h0, rows[i].fb});
         wr(`SPD_CMD_OFF, {rows[i].k, 14'h0, rows[i].v});
         rd(`SPD_TARGET_OFF);
         chk("target", {16'h0, rows[i].x}, r);
      end
      rd(12'h01c);
      chk("slverr", 32'h1, e);
      stop;
      p = cxp;
      wr(`SPD_CTRL_OFF, 32'h7);
      repeat (2) @(posedge clk);
      chk("coil_swap", !p, cxp);
      wr(`SPD_CTRL_OFF, 32'hf);
      repeat (3) @(posedge clk);
      chk("coil_run", p, cxp);
      wr(`SPD_CTRL_OFF, 32'h3);
      stop;
      wr(`SPD_CMD_OFF, {16'h0, a[15:0] + 16'h7fff});
      rd(`SPD_STATUS_OFF);
      p = r[3];
      wr(`SPD_CMD_OFF, {16'h0, a[15:0] + 16'h8001});
      rd(`SPD_STATUS_OFF);
      chk("dir", !p, r[3]);
      stop;
      wr(`SPD_THR_OFF, 32'h1000);
      wr(`SPD_CMD_OFF, {16'h0, a[15:0] + 16'h0100});
      pulse;
      chk("moving", 32'h1, mov);
      pulse;
      chk("moving", 32'h0, mov);
      rd(`SPD_STATUS_OFF);
      chk("stalled", 32'h1, r[1]);
      otp_sh <= 1'b1;
      rst(11'h401);
      rd(`SPD_CTRL_OFF);
      chk("ctrl_otp", 32'h7, r);
      rd(`SPD_FBPOS_OFF);
      chk("fbpos", 32'h400, r);
      rd(`SPD_STATUS_OFF);
      chk("fb_off", 32'h1, r[2]);
      close_out;
   end
endmodule // tb_stepper_position_word_decoder
bind spd_positioner spd_props #(.STEP_CYCLES(STEP_CYCLES), .BEMF_W(BEMF_W)) i_props (
   .clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
   .otp_fallback, .otp_shaft, .bemf_sample, .bemf_valid, .coil_x_plus_pin,
   .coil_x_minus_pin, .coil_y_sign, .step_pulse, .moving);
